// ### verilog/oled_pkg.sv
// Shared constants for the display power sequencer and panel controller
// How it works
// - Host raises logic, booster; off, init, clear first
// - Wait 100ms after panel supply before on
// - Power down: display off before supplies drop
// - 100ms discharge before logic supply removal
// - Reset forces display off, full 128x64 mode
// - Reset selects non-remapped column and row mapping
// - Reset clears partial serial shift register bits
// - Reset sets display start line to zero
// - Reset zeroes the column address counter
// - Reset selects normal row scan direction
// - Reset loads contrast with 7Fh
// - Reset selects normal display, as A4h
// - Host may reset the panel to recover
package oled_pkg;
    // ==================================================
    // Command codes understood by the panel controller
    localparam logic [7:0] CMD_DISP_OFF = 8'hae;
    localparam logic [7:0] CMD_DISP_ON = 8'haf;
    localparam logic [7:0] CMD_CONTRAST = 8'h81;
    localparam logic [7:0] CMD_FOLLOW_RAM = 8'ha4;
    localparam logic [7:0] CMD_ALL_LIT = 8'ha5;
    localparam logic [7:0] CMD_INV_OFF = 8'ha6;
    localparam logic [7:0] CMD_INV_ON = 8'ha7;
    localparam logic [7:0] CMD_COL_NORM = 8'ha0;
    localparam logic [7:0] CMD_COL_REMAP = 8'ha1;
    localparam logic [7:0] CMD_SCAN_NORM = 8'hc0;
    localparam logic [7:0] CMD_SCAN_REV = 8'hc8;
    localparam logic [7:0] CMD_MUX = 8'ha8;
    localparam logic [7:0] CMD_OFFSET = 8'hd3;
    localparam logic [7:0] CMD_PUMP = 8'h8d;
    localparam logic [1:0] START_LINE_TOP = 2'h1;
    localparam logic [3:0] PAGE_TOP = 4'hb;
    // ==================================================
    // Reset values, address limits and sequence lengths
    localparam logic [7:0] CONTRAST_RST = 8'h7f;
    localparam logic [5:0] MUX_RST = 6'h3f;
    localparam logic [6:0] COL_LAST = 7'h7f;
    localparam logic [2:0] PAGE_LAST = 3'h7;
    localparam int CLEAR_BYTES = 1024;
    localparam int INIT_LEN = 12;
    // ==================================================
    // Host register map, byte addresses
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_CMD = 12'h008;
    localparam int CTRL_UP = 0;
    localparam int CTRL_DOWN = 1;
    localparam int CTRL_RESET = 2;
    localparam int CMD_DC = 8;
    localparam int STAT_BUSY = 4;
    localparam int STAT_PEND = 5;
    // ==================================================
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_MS = 100;
    localparam int SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000;
    localparam int RST_LOW_NS = 10000;
    localparam int RST_LOW_CYC = RST_LOW_NS * CLK_MHZ / 1000;
    localparam int BIT_DIV = 4;
    // ==================================================
    // Host sequencer states
    typedef enum logic [3:0] {
        S_OFF = 4'h0,
        S_RESET = 4'h1,
        S_BLANK = 4'h2,
        S_INIT = 4'h3,
        S_CLEAR = 4'h4,
        S_SETTLE = 4'h5,
        S_LIGHT = 4'h6,
        S_ON = 4'h7,
        S_DOWN_BLANK = 4'h8,
        S_DISCHARGE = 4'h9,
        S_RECOVER = 4'ha
    } host_state_t;

    // Initialisation list sent between blanking and clearing
    function automatic logic [7:0] init_byte(input logic [3:0] idx);
        logic [7:0] b;
        b = CMD_FOLLOW_RAM;
        case (idx)
            4'h0: b = CMD_MUX;
            4'h1: b = 8'h3f;
            4'h2: b = CMD_OFFSET;
            4'h3: b = 8'h00;
            4'h4: b = 8'h40;
            4'h5: b = CMD_PUMP;
            4'h6: b = 8'h14;
            4'h7: b = CMD_COL_REMAP;
            4'h8: b = CMD_SCAN_REV;
            4'h9: b = CMD_CONTRAST;
            4'ha: b = 8'hcf;
            default: b = CMD_FOLLOW_RAM;
        endcase
        return b;
    endfunction
endpackage

// ### verilog/oled_link_if.sv
// Link between the host sequencer and the panel controller
`timescale 1ns/1ps
`default_nettype none
interface oled_link_if;
    logic logic_supply;    // Logic rail enable
    logic booster_supply;  // Booster rail enable
    logic panel_supply;    // Panel high voltage enable
    logic panel_reset_n;   // Panel reset, active low
    logic link_sel;        // Byte frame active
    logic link_dc;         // High for display data, low for command
    logic link_bit;        // Serial bit, msb first
    logic link_strobe;     // One-cycle pulse: link_bit valid

    modport host (
        output logic_supply, booster_supply, panel_supply, panel_reset_n,
        output link_sel, link_dc, link_bit, link_strobe
    );
    modport device (
        input logic_supply, booster_supply, panel_supply, panel_reset_n,
        input link_sel, link_dc, link_bit, link_strobe
    );
endinterface
`default_nettype wire

// ### verilog/oled_panel_ctrl.sv
// Panel controller end: serial command receiver and display state
`timescale 1ns/1ps
`default_nettype none
module oled_panel_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    oled_link_if.device link,
    output logic display_on,
    output logic [7:0] contrast,
    output logic [5:0] start_line,
    output logic [6:0] column,
    output logic [2:0] page,
    output logic col_remap,
    output logic scan_reverse,
    output logic all_lit,
    output logic inverse,
    output logic [5:0] mux_ratio,
    output logic [5:0] row_offset,
    output logic pump_on,
    output logic [15:0] data_count
);
    import oled_pkg::*;

    // ==================================================
    // State registers
    logic [7:0] sh_q, sh_d;        // Serial shift register
    logic [2:0] cnt_q, cnt_d;      // Bits received in this byte
    logic [7:0] op_q, op_d;        // Command waiting for its argument
    logic arg_q, arg_d;            // Next command byte is an argument
    logic disp_q, disp_d;          // Display on
    logic [7:0] con_q, con_d;      // Contrast
    logic [5:0] start_q, start_d;  // Start line
    logic [6:0] col_q, col_d;      // Column address counter
    logic [2:0] page_q, page_d;    // Page address
    logic remap_q, remap_d;        // Column remap
    logic scan_q, scan_d;          // Row scan reversed
    logic lit_q, lit_d;            // Entire display lit
    logic inv_q, inv_d;            // Inverse video
    logic [5:0] mux_q, mux_d;      // Multiplex ratio minus one
    logic [5:0] ofs_q, ofs_d;      // Row offset
    logic pump_q, pump_d;          // Charge pump enable
    logic [15:0] dcnt_q, dcnt_d;   // Data bytes taken since reset

    // ==================================================
    // Decode of the link
    // Without its logic rail the controller is held in reset as well,
    // so a rail that comes up always starts from defaults.
    wire hold = !link.logic_supply || !link.panel_reset_n;
    wire take = link.link_sel && link.link_strobe;
    wire last_bit = take && (cnt_q == 3'h7);
    wire [7:0] rx = {sh_q[6:0], link.link_bit};
    wire is_cmd = last_bit && !link.link_dc;
    wire is_data = last_bit && link.link_dc;
    wire col_wrap = (col_q == COL_LAST);

    // ==================================================
    // Next state
    always_comb begin
        sh_d = sh_q;
        cnt_d = cnt_q;
        op_d = op_q;
        arg_d = arg_q;
        disp_d = disp_q;
        con_d = con_q;
        start_d = start_q;
        col_d = col_q;
        page_d = page_q;
        remap_d = remap_q;
        scan_d = scan_q;
        lit_d = lit_q;
        inv_d = inv_q;
        mux_d = mux_q;
        ofs_d = ofs_q;
        pump_d = pump_q;
        dcnt_d = dcnt_q;
        if (!link.link_sel) begin
            // A dropped frame discards a partial byte
            cnt_d = 3'h0;
        end else if (take) begin
            sh_d = rx;
            cnt_d = cnt_q + 3'h1;
        end
        if (is_data) begin
            // Display data advances column, then page
            col_d = col_wrap ? 7'h00 : col_q + 7'h01;
            if (col_wrap) begin
                page_d = page_q + 3'h1;
            end
            dcnt_d = dcnt_q + 16'h0001;
        end else if (is_cmd && arg_q) begin
            // Argument byte of a two-byte command
            arg_d = 1'b0;
            unique case (op_q)
                CMD_CONTRAST: con_d = rx;
                CMD_MUX: mux_d = rx[5:0];
                CMD_OFFSET: ofs_d = rx[5:0];
                CMD_PUMP: pump_d = rx[2];
                default: ;
            endcase
        end else if (is_cmd) begin
            unique casez (rx)
                CMD_DISP_OFF: disp_d = 1'b0;
                CMD_DISP_ON: disp_d = 1'b1;
                CMD_FOLLOW_RAM: lit_d = 1'b0;
                CMD_ALL_LIT: lit_d = 1'b1;
                CMD_INV_OFF: inv_d = 1'b0;
                CMD_INV_ON: inv_d = 1'b1;
                CMD_COL_NORM: remap_d = 1'b0;
                CMD_COL_REMAP: remap_d = 1'b1;
                CMD_SCAN_NORM: scan_d = 1'b0;
                CMD_SCAN_REV: scan_d = 1'b1;
                CMD_CONTRAST, CMD_MUX, CMD_OFFSET, CMD_PUMP: begin
                    op_d = rx;
                    arg_d = 1'b1;
                end
                8'b0000_????: col_d = {col_q[6:4], rx[3:0]};
                8'b0001_????: col_d = {rx[2:0], col_q[3:0]};
                8'b01??_????: start_d = rx[5:0];
                8'b1011_0???: page_d = rx[2:0];
                // Codes this block does not model are ignored
                default: ;
            endcase
        end
    end

    // ==================================================
    // Shift register and argument tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            op_q <= 8'h00;
            arg_q <= 1'b0;
        end else if (hold) begin
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            op_q <= 8'h00;
            arg_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            arg_q <= arg_d;
        end
    end

    // ==================================================
    // Display mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_q <= 1'b0;
            mux_q <= MUX_RST;
            lit_q <= 1'b0;
            inv_q <= 1'b0;
            pump_q <= 1'b0;
            ofs_q <= 6'h00;
        end else if (hold) begin
            disp_q <= 1'b0;
            mux_q <= MUX_RST;
            lit_q <= 1'b0;
            inv_q <= 1'b0;
            pump_q <= 1'b0;
            ofs_q <= 6'h00;
        end else begin
            disp_q <= disp_d;
            mux_q <= mux_d;
            lit_q <= lit_d;
            inv_q <= inv_d;
            pump_q <= pump_d;
            ofs_q <= ofs_d;
        end
    end

    // ==================================================
    // Addressing and contrast registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remap_q <= 1'b0;
            scan_q <= 1'b0;
            start_q <= 6'h00;
            col_q <= 7'h00;
            page_q <= 3'h0;
            con_q <= CONTRAST_RST;
            dcnt_q <= 16'h0000;
        end else if (hold) begin
            remap_q <= 1'b0;
            scan_q <= 1'b0;
            start_q <= 6'h00;
            col_q <= 7'h00;
            page_q <= 3'h0;
            con_q <= CONTRAST_RST;
            dcnt_q <= 16'h0000;
        end else begin
            remap_q <= remap_d;
            scan_q <= scan_d;
            start_q <= start_d;
            col_q <= col_d;
            page_q <= page_d;
            con_q <= con_d;
            dcnt_q <= dcnt_d;
        end
    end

    // ==================================================
    // Outputs straight from the registers
    assign display_on = disp_q;
    assign contrast = con_q;
    assign start_line = start_q;
    assign column = col_q;
    assign page = page_q;
    assign col_remap = remap_q;
    assign scan_reverse = scan_q;
    assign all_lit = lit_q;
    assign inverse = inv_q;
    assign mux_ratio = mux_q;
    assign row_offset = ofs_q;
    assign pump_on = pump_q;
    assign data_count = dcnt_q;
endmodule
`default_nettype wire

// ### verilog/oled_power_host.sv
// Host end: APB-controlled supply and command sequencer
`timescale 1ns/1ps
`default_nettype none
module oled_power_host #(
    parameter int unsigned SETTLE_CYCLES = oled_pkg::SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    oled_link_if.host link
);
    import oled_pkg::*;

    // ==================================================
    // Registers
    host_state_t st_q, st_d;
    logic [31:0] wait_q, wait_d;   // Delay counter
    logic [10:0] idx_q, idx_d;     // Byte index within a phase
    logic sent_q, sent_d;          // Current byte handed to sender
    logic [8:0] ucmd_q;            // User byte with dc flag
    logic upend_q;                 // User byte waiting
    logic rdy_q, err_q;
    logic [31:0] rd_q;
    logic logic_q, boost_q, vcc_q, rstn_q;
    logic [1:0] div_q;             // Bit rate divider
    logic busy_q;
    logic [2:0] bcnt_q;
    logic [7:0] tsh_q;
    logic sel_q, dc_q, bit_q, stb_q;

    // ==================================================
    // Bus decode; one wait state, so every answer is registered
    wire acc = psel && penable && !rdy_q;
    wire wr = acc && pwrite;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_stat = (paddr == OFS_STATUS);
    wire hit_cmd = (paddr == OFS_CMD);
    wire bad = !(hit_ctrl || hit_stat || hit_cmd);
    wire up_req = wr && hit_ctrl && pwdata[CTRL_UP];
    wire down_req = wr && hit_ctrl && pwdata[CTRL_DOWN];
    wire rst_req = wr && hit_ctrl && pwdata[CTRL_RESET];
    wire cmd_wr = wr && hit_cmd && !upend_q;
    wire bit_en = (div_q == 2'(BIT_DIV - 1));
    wire tx_idle = !busy_q && !sel_q;
    wire [31:0] status = {26'h0, upend_q, busy_q, st_q};

    // ==================================================
    // Sequencer next state
    logic tx_go;
    logic [7:0] tx_byte;
    logic tx_dc, user_take;
    always_comb begin
        st_d = st_q;
        wait_d = wait_q + 32'h1;
        idx_d = idx_q;
        sent_d = sent_q;
        tx_go = 1'b0;
        tx_byte = CMD_DISP_OFF;
        tx_dc = 1'b0;
        user_take = 1'b0;
        unique case (st_q)
            S_OFF: if (up_req) begin
                st_d = S_RESET;
                wait_d = 32'h0;
            end
            S_RESET, S_RECOVER: if (wait_q == 32'(RST_LOW_CYC - 1)) begin
                st_d = S_BLANK;
                sent_d = 1'b0;
            end
            S_BLANK, S_DOWN_BLANK, S_LIGHT: begin
                tx_byte = (st_q == S_LIGHT) ? CMD_DISP_ON : CMD_DISP_OFF;
                if (tx_idle && sent_q) begin
                    sent_d = 1'b0;
                    idx_d = 11'h0;
                    wait_d = 32'h0;
                    st_d = (st_q == S_BLANK) ? S_INIT :
                        (st_q == S_LIGHT) ? S_ON : S_DISCHARGE;
                end else if (tx_idle) begin
                    tx_go = 1'b1;
                    sent_d = 1'b1;
                end
            end
            S_INIT, S_CLEAR: begin
                tx_byte = (st_q == S_INIT) ? init_byte(idx_q[3:0]) : 8'h00;
                tx_dc = (st_q == S_CLEAR);
                if (tx_idle && sent_q) begin
                    sent_d = 1'b0;
                    idx_d = idx_q + 11'h1;
                    wait_d = 32'h0;
                    if (st_q == S_INIT && idx_q == 11'(INIT_LEN - 1)) begin
                        st_d = S_CLEAR;
                        idx_d = 11'h0;
                    end else if (idx_q == 11'(CLEAR_BYTES - 1)) begin
                        st_d = S_SETTLE;
                    end
                end else if (tx_idle) begin
                    tx_go = 1'b1;
                    sent_d = 1'b1;
                end
            end
            S_SETTLE: if (wait_q == SETTLE_CYCLES - 1) begin
                st_d = S_LIGHT;
                sent_d = 1'b0;
            end
            S_ON: begin
                tx_byte = ucmd_q[7:0];
                tx_dc = ucmd_q[CMD_DC];
                if (down_req && tx_idle && !upend_q) begin
                    st_d = S_DOWN_BLANK;
                    sent_d = 1'b0;
                end else if (rst_req && tx_idle && !upend_q) begin
                    st_d = S_RECOVER;
                    wait_d = 32'h0;
                end else if (upend_q && tx_idle) begin
                    tx_go = 1'b1;
                    user_take = 1'b1;
                end
            end
            S_DISCHARGE: if (wait_q == SETTLE_CYCLES - 1) begin
                st_d = S_OFF;
            end
            default: st_d = S_OFF;
        endcase
    end

    // ==================================================
    // Sequencer and supply registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_OFF;
            wait_q <= 32'h0;
            idx_q <= 11'h0;
            sent_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wait_q <= wait_d;
            idx_q <= idx_d;
            sent_q <= sent_d;
        end
    end

    // Rails follow the state; the panel rail rises at settle and holds
    // through a recovery reset, dropping only when discharge begins
    wire rails = (st_d != S_OFF) && (st_d != S_DISCHARGE);
    wire hv = (st_d == S_SETTLE) || (vcc_q && rails);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            logic_q <= 1'b0;
            boost_q <= 1'b0;
            vcc_q <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            logic_q <= (st_d != S_OFF);
            boost_q <= rails;
            vcc_q <= hv;
            rstn_q <= rails && (st_d != S_RESET) && (st_d != S_RECOVER);
        end
    end

    // ==================================================
    // APB slave: pready rises one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 32'h0;
            upend_q <= 1'b0;
            ucmd_q <= 9'h0;
        end else begin
            rdy_q <= acc;
            err_q <= acc && bad;
            rd_q <= (acc && !pwrite && hit_stat) ? status : 32'h0;
            // Only while on; a second write before send is dropped
            if (cmd_wr && st_q == S_ON) begin
                upend_q <= 1'b1;
                ucmd_q <= pwdata[8:0];
            end else if (user_take) begin
                upend_q <= 1'b0;
            end
        end
    end

    // ==================================================
    // Serial byte sender, msb first, one bit per divider tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            busy_q <= 1'b0;
            bcnt_q <= 3'h0;
            tsh_q <= 8'h00;
            sel_q <= 1'b0;
            dc_q <= 1'b0;
            bit_q <= 1'b0;
            stb_q <= 1'b0;
        end else begin
            div_q <= bit_en ? 2'h0 : div_q + 2'h1;
            stb_q <= 1'b0;
            if (tx_go) begin
                busy_q <= 1'b1;
                bcnt_q <= 3'h0;
                tsh_q <= tx_byte;
                sel_q <= 1'b1;
                dc_q <= tx_dc;
            end else if (busy_q && bit_en) begin
                bit_q <= tsh_q[7];
                stb_q <= 1'b1;
                tsh_q <= {tsh_q[6:0], 1'b0};
                bcnt_q <= bcnt_q + 3'h1;
                busy_q <= (bcnt_q != 3'h7);
            end else if (!busy_q && bit_en) begin
                sel_q <= 1'b0;
            end
        end
    end

    assign prdata = rd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign link.logic_supply = logic_q;
    assign link.booster_supply = boost_q;
    assign link.panel_supply = vcc_q;
    assign link.panel_reset_n = rstn_q;
    assign link.link_sel = sel_q;
    assign link.link_dc = dc_q;
    assign link.link_bit = bit_q;
    assign link.link_strobe = stb_q;
endmodule
`default_nettype wire

// ### verification/oled_link_sva.sv
// Assertions on the supply and command link
`timescale 1ns/1ps
`default_nettype none
module oled_link_sva #(
    parameter int SETTLE = 200
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic logic_supply,
    input wire logic booster_supply,
    input wire logic panel_supply,
    input wire logic panel_reset_n,
    input wire logic link_sel,
    input wire logic link_dc,
    input wire logic link_bit,
    input wire logic link_strobe
);
    import oled_pkg::*;
    // ========================================
    // Byte and rail tracking
    logic [7:0] sh_q; // Byte in flight
    logic [7:0] cmd_q; // Last whole command byte
    logic [2:0] nb_q; // Bits taken
    logic [10:0] nd_q; // Data bytes since logic rail rose
    int hv_q; // Cycles panel rail on, saturating
    int dn_q; // Cycles booster off, saturating
    wire logic take = link_sel & link_strobe;
    wire logic done = take && nb_q == 3'h7;
    wire logic [7:0] byte_d = {sh_q[6:0], link_bit};
    // A dropped frame discards a partial byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sh_q, cmd_q, nb_q, nd_q} <= '0;
            {hv_q, dn_q} <= '0;
        end else begin
            sh_q <= take ? byte_d : sh_q;
            nb_q <= link_sel ? nb_q + 3'(take) : 3'h0;
            cmd_q <= done && !link_dc ? byte_d : cmd_q;
            nd_q <= logic_supply ? nd_q + 11'(done & link_dc) : 11'h000;
            hv_q <= panel_supply ? hv_q + int'(hv_q < SETTLE) : 0;
            dn_q <= booster_supply ? 0 : dn_q + int'(dn_q < SETTLE);
        end
    end
    // ========================================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_rail_order: assert property (panel_supply |-> booster_supply)
        else $error("panel rail on without booster rail");
    a_clear_first: assert property (
        $rose(panel_supply) |-> nd_q == 11'h400)
        else $error("panel rail rose before a full clear");
    a_settle_on: assert property (
        done && !link_dc && byte_d == CMD_DISP_ON |-> hv_q >= SETTLE)
        else $error("display on before panel rail settled");
    a_quiet_settle: assert property (
        $rose(panel_supply) |=> !link_sel [*8])
        else $error("link busy while panel rail settles");
    a_off_first: assert property (
        $fell(panel_supply) |-> $fell(booster_supply) && cmd_q == CMD_DISP_OFF)
        else $error("rails dropped without display off");
    a_discharge: assert property (
        $fell(logic_supply) |-> dn_q >= SETTLE - 1 && !panel_supply)
        else $error("logic rail dropped before discharge");
    a_booster_logic: assert property (booster_supply |-> logic_supply)
        else $error("booster rail on without logic rail");
    a_reset_quiet: assert property (
        !panel_reset_n |-> !link_sel && !link_strobe)
        else $error("link active while panel held in reset");
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Bench: host sequencer and panel controller joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import oled_pkg::*;
    // ========================================
    // Signals
    localparam int SETTLE = 200; // Short settle keeps the run brief
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd; // rd: last read word
    logic display_on, col_remap, scan_reverse, all_lit, inverse, pump_on;
    logic [7:0] contrast;
    logic [5:0] start_line, mux_ratio, row_offset;
    logic [6:0] column;
    logic [2:0] page;
    logic [15:0] data_count;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    oled_link_if link ();
    oled_power_host #(.SETTLE_CYCLES(SETTLE)) i_oled_power_host (.*);
    oled_panel_ctrl i_oled_panel_ctrl (.*);
    oled_link_sva #(.SETTLE(SETTLE)) i_oled_link_sva (.pclk(pclk),
        .presetn(presetn), .logic_supply(link.logic_supply),
        .booster_supply(link.booster_supply), .link_dc(link.link_dc),
        .panel_supply(link.panel_supply), .link_bit(link.link_bit),
        .panel_reset_n(link.panel_reset_n), .link_sel(link.link_sel),
        .link_strobe(link.link_strobe));
    // Clock, 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Cut a hang short; two power ups take under 90k cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 99000) begin
            fails++;
            give_verdict();
        end
    end
    // ========================================
    // Helpers
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic wait_state(input logic [3:0] s);
        do apb(1'b0, OFS_STATUS, 32'h0); while (rd[3:0] !== s);
    endtask
    // Send a user byte and wait until it has left the sender
    task automatic cmd(input logic [7:0] b, input logic dc);
        apb(1'b1, OFS_CMD, {23'h0, dc, b});
        do apb(1'b0, OFS_STATUS, 32'h0); while (rd[5:4] !== 2'h0);
    endtask
    // Device state expected while its reset is applied
    task automatic defaults();
        check(32'(display_on), 32'h0);
        check(32'(mux_ratio), 32'h3f);
        check(32'(col_remap), 32'h0);
        check(32'(start_line), 32'h0);
        check(32'(column), 32'h0);
        check(32'(scan_reverse), 32'h0);
        check(32'(contrast), 32'h7f);
        check(32'({all_lit, inverse}), 32'h0);
    endtask
    // ========================================
    // Scenarios
    task automatic t_bus();
        apb(1'b0, 12'h00c, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_up();
        apb(1'b1, OFS_CTRL, 32'h1);
        wait_state(4'h7);
        check(32'(link.panel_supply), 32'h1);
        check(32'(display_on), 32'h1);
        check(32'(data_count), 32'h400);
        check(32'({pump_on, row_offset, page}), 32'h200);
    endtask
    // Panel reset in mid-run wipes user settings, then relights
    task automatic t_recover();
        cmd(8'ha5, 1'b0);
        cmd(8'ha7, 1'b0);
        cmd(8'h45, 1'b0);
        cmd(8'h5a, 1'b1);
        check(32'({inverse, all_lit, start_line, column}), 32'h6281);
        apb(1'b1, OFS_CTRL, 32'h4);
        while (link.panel_reset_n !== 1'b0) @(posedge pclk);
        repeat (2) @(posedge pclk);
        defaults();
        wait_state(4'h7);
        check(32'(display_on), 32'h1);
    endtask
    task automatic t_down();
        apb(1'b1, OFS_CTRL, 32'h2);
        wait_state(4'h0);
        check(32'(display_on), 32'h0);
        check(32'({link.logic_supply, link.booster_supply}), 32'h0);
    endtask
    // ========================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        defaults();
        t_bus();
        t_up();
        t_recover();
        t_down();
        give_verdict();
    end
endmodule
`default_nettype wire
